// file: ufcs_uart.sv
// Serial transceiver with frame configuration, status flags, 4-deep FIFOs.
// Assumes an APB master on pclk and a remote node on the serial lines.
// Contract
// - Receive inversion set makes low the receive idle level in plain mode, high in infrared mode.
// - Bit period is 4 baud ticks in high speed, else 16.
// - Field 11 nine bits, 10 odd parity, 01 even, 00 none.
// - Stop select set sends two stop bits, else one.
// - Infrared coding acts only in 16x oversampling mode.
// - Transmit event on load, load leaving buffer empty, or done.
// - Transmit inversion flips idle level, in plain and infrared modes.
// - Break request sends start, twelve zeros, stop, then self-clears.
// - Transmit disable aborts, flushes buffer, releases the pin.
// - Buffer-full flag set while no transmit slot is free.
// - Transmitter-empty flag set only when shifter and buffer empty.
// - Receive event at four, three, or every stored character.
// - Address detect in nine-bit mode keeps only ninth-bit-one characters.
// - Receiver-idle flag reads one while no character is in progress.
// - Parity error flag belongs to the head receive character.
// - Framing error flag belongs to the head receive character.
// - Overflow sets overrun; clearing it empties receive buffer and shifter.
// - Data-available flag set while receive buffer is not empty.
// - Transmit and receive buffers are four-deep first-in first-out.
// - Module enable hands pins to the transceiver; clear keeps it inactive.
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ps
`include "ufcs_cfg.svh"

module ufcs_uart (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial lines
  input wire logic serial_receive_line,
  output logic serial_transmit_line,
  output logic serial_transmit_oe,
  // Events
  output logic tx_irq,
  output logic rx_irq
);

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic logic par_bit(input logic [7:0] d, input logic odd);
    par_bit = (^d) ^ odd;
  endfunction

  function automatic logic [1:0] fifo_wp(input logic [1:0] rp, input logic [2:0] cnt);
    fifo_wp = rp + cnt[1:0];
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [15:0] mode_q, ctl_q, div_q, div_cnt_q;
  logic brk_q, overrun_error_q, pready_q, pslverr_q, tx_irq_q, rx_irq_q, tx_line_q, tx_oe_q;
  logic [31:0] prdata_q;
  logic [8:0] tx_mem_q [4];
  logic [10:0] rx_mem_q [4];
  logic [1:0] tx_rp_q, rx_rp_q;
  logic [2:0] tx_cnt_q, rx_cnt_q;
  ufcs_pkg::ufcs_tx_state_t tx_state_q, tx_nstate;
  ufcs_pkg::ufcs_rx_state_t rx_state_q;
  logic [4:0] tx_os_q, rx_os_q;
  logic [3:0] tx_idx_q, tx_nidx, rx_idx_q;
  logic [8:0] tx_sh_q, rx_sh_q;
  logic tx_brk_run_q, tx_level, rx_s1_q, rx_s2_q, rx_parity_error_q;

  // ---------------------------------------------------------------
  // Configuration decode
  // ---------------------------------------------------------------
  wire en = mode_q[`UFCS_M_EN];
  wire high_speed_baud_select = mode_q[`UFCS_M_HIGH_SPEED_BAUD_SELECT];
  wire [1:0] pdsel = mode_q[`UFCS_M_PDS_HI:`UFCS_M_PDS_LO];
  wire ir_on = mode_q[`UFCS_M_INFRARED_CODEC_ENABLE] & ~high_speed_baud_select;
  wire [4:0] osr = high_speed_baud_select ? `UFCS_OSR_HI : `UFCS_OSR_STD;
  wire [4:0] osr_last = osr - 5'd1;
  wire [4:0] osr_half = (osr >> 1) - 5'd1;
  wire nine = (pdsel == `UFCS_PDS_9N);
  wire par_on = (pdsel == `UFCS_PDS_8O) || (pdsel == `UFCS_PDS_8E);
  wire par_odd = (pdsel == `UFCS_PDS_8O);
  wire [3:0] data_last = nine ? `UFCS_LAST9 : `UFCS_LAST8;
  wire [3:0] stop_last = mode_q[`UFCS_M_STOP_BITS_SELECT] ? 4'd1 : 4'd0;
  wire [1:0] txisel = {ctl_q[`UFCS_S_TXI1], ctl_q[`UFCS_S_TXI0]};
  wire txinv = ctl_q[`UFCS_S_TXINV];
  wire txen = ctl_q[`UFCS_S_TXEN];
  wire [1:0] rxisel = ctl_q[`UFCS_S_RXI_HI:`UFCS_S_RXI_LO];
  wire address_detect_enable = ctl_q[`UFCS_S_ADDRESS_DETECT_ENABLE];
  wire baud_tick = en & (div_cnt_q == div_q);

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  wire setup = psel & ~penable;
  wire access = psel & penable & pready_q;
  wire wr = access & pwrite;
  wire rd = access & ~pwrite;
  wire sel_mode = (paddr == `UFCS_OFF_MODE);
  wire sel_stat = (paddr == `UFCS_OFF_STAT);
  wire sel_txd = (paddr == `UFCS_OFF_TXD);
  wire sel_rxd = (paddr == `UFCS_OFF_RXD);
  wire sel_div = (paddr == `UFCS_OFF_DIV);
  wire mapped = sel_mode | sel_stat | sel_txd | sel_rxd | sel_div;

  // ---------------------------------------------------------------
  // Flags and FIFO traffic
  // ---------------------------------------------------------------
  wire tx_full = (tx_cnt_q == `UFCS_DEPTH);
  wire transmitter_empty = (tx_cnt_q == 3'd0) && (tx_state_q == ufcs_pkg::TX_IDLE);
  wire rx_avail = (rx_cnt_q != 3'd0);
  wire receiver_idle = (rx_state_q == ufcs_pkg::RX_IDLE);
  wire [10:0] rx_head = rx_mem_q[rx_rp_q];
  wire parity_error = rx_avail & rx_head[10];
  wire framing_error = rx_avail & rx_head[9];
  wire tx_flush = ~en | ~txen;
  wire tx_push = wr & sel_txd & ~tx_flush & ~tx_full;
  wire tx_start = ~tx_flush && (tx_state_q == ufcs_pkg::TX_IDLE) && (brk_q || tx_cnt_q != 3'd0);
  wire tx_load = tx_start & ~brk_q;
  wire tx_bit_end = baud_tick && (tx_os_q == osr_last);
  wire tx_done = tx_bit_end && (tx_state_q == ufcs_pkg::TX_STOP) && (tx_idx_q == stop_last);
  wire brk_done = tx_done & tx_brk_run_q;
  wire rx_level = ir_on ? ~(rx_s2_q ^ mode_q[`UFCS_M_RXINV]) : (rx_s2_q ^ mode_q[`UFCS_M_RXINV]);
  wire rx_sample = baud_tick && (rx_os_q == osr_last);
  wire rx_end = rx_sample && (rx_state_q == ufcs_pkg::RX_STOP);
  wire rx_keep = ~(address_detect_enable & nine & ~rx_sh_q[8]);
  wire rx_full = (rx_cnt_q == `UFCS_DEPTH);
  wire rx_ovf = rx_end & rx_keep & rx_full;
  wire rx_push = rx_end & rx_keep & ~rx_full & ~overrun_error_q;
  wire rx_pop = rd & sel_rxd & rx_avail;
  wire overrun_error_clr = wr && sel_stat && !pwdata[`UFCS_S_OVERRUN_ERROR] && overrun_error_q && !rx_ovf;
  wire rx_flush = ~en | overrun_error_clr;
  wire ir_pulse = ~tx_level && (tx_os_q < `UFCS_IR_PULSE);
  wire tx_pin = ir_on ? (txinv ^ ir_pulse) : (txinv ^ tx_level);
  wire tx_irq_d = (txisel == `UFCS_TXI_EACH && tx_load)
    || (txisel == `UFCS_TXI_EMPTY && tx_load && tx_cnt_q == 3'd1 && !tx_push)
    || (txisel == `UFCS_TXI_DONE && tx_done && tx_cnt_q == 3'd0);
  wire rx_irq_d = rx_push && (rxisel == `UFCS_RXI_FULL ? rx_cnt_q == `UFCS_LVL_FULL :
    rxisel == `UFCS_RXI_3Q ? rx_cnt_q == `UFCS_LVL_3Q : 1'b1);
  wire [15:0] stat_word = {txisel[1], txinv, txisel[0], 1'b0, brk_q, txen, tx_full, transmitter_empty,
    rxisel, address_detect_enable, receiver_idle, parity_error, framing_error, overrun_error_q, rx_avail};
  wire [31:0] rd_word = sel_mode ? {16'h0000, mode_q} :
    sel_stat ? {16'h0000, stat_word} :
    sel_rxd ? {23'h000000, rx_head[8:0]} :
    sel_div ? {16'h0000, div_q} : 32'h00000000;

  // ---------------------------------------------------------------
  // Transmit sequencing and line level
  // ---------------------------------------------------------------
  always_comb begin
    tx_nstate = tx_state_q;
    tx_nidx = tx_idx_q + 4'h1;
    tx_level = 1'b1;
    unique case (tx_state_q)
      ufcs_pkg::TX_IDLE: begin
        tx_nidx = 4'h0;
      end
      ufcs_pkg::TX_START: begin
        tx_level = 1'b0;
        tx_nstate = tx_brk_run_q ? ufcs_pkg::TX_BRK : ufcs_pkg::TX_DATA;
        tx_nidx = 4'h0;
      end
      ufcs_pkg::TX_DATA: begin
        tx_level = tx_sh_q[0];
        if (tx_idx_q == data_last) begin
          tx_nstate = par_on ? ufcs_pkg::TX_PAR : ufcs_pkg::TX_STOP;
          tx_nidx = 4'h0;
        end
      end
      ufcs_pkg::TX_PAR: begin
        tx_level = tx_sh_q[8];
        tx_nstate = ufcs_pkg::TX_STOP;
        tx_nidx = 4'h0;
      end
      ufcs_pkg::TX_BRK: begin
        tx_level = 1'b0;
        if (tx_idx_q == `UFCS_BRK_LAST) begin
          tx_nstate = ufcs_pkg::TX_STOP;
          tx_nidx = 4'h0;
        end
      end
      ufcs_pkg::TX_STOP: begin
        if (tx_idx_q == stop_last) begin
          tx_nstate = ufcs_pkg::TX_IDLE;
          tx_nidx = 4'h0;
        end
      end
      default: begin
        tx_nstate = ufcs_pkg::TX_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Register file and APB answer
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= `UFCS_MODE_RST;
      ctl_q <= `UFCS_CTL_RST;
      div_q <= `UFCS_DIV_RST;
      brk_q <= 1'b0;
      overrun_error_q <= 1'b0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
      tx_irq_q <= 1'b0;
      rx_irq_q <= 1'b0;
      tx_line_q <= 1'b1;
      tx_oe_q <= 1'b0;
    end else if (ce) begin
      pready_q <= setup;
      if (setup) begin
        prdata_q <= rd_word;
        pslverr_q <= ~mapped;
      end
      if (wr && sel_mode) begin
        mode_q <= pwdata[15:0] & `UFCS_MODE_WMASK;
      end
      if (wr && sel_stat) begin
        ctl_q <= pwdata[15:0] & `UFCS_STAT_WMASK;
      end
      if (wr && sel_div) begin
        div_q <= pwdata[15:0];
      end
      brk_q <= (wr && sel_stat && pwdata[`UFCS_S_BRK]) || (brk_q && !brk_done);
      overrun_error_q <= rx_ovf || (overrun_error_q && !overrun_error_clr);
      tx_irq_q <= tx_irq_d;
      rx_irq_q <= rx_irq_d;
      tx_line_q <= tx_pin;
      tx_oe_q <= ~tx_flush;
    end
  end

  // ---------------------------------------------------------------
  // Baud generator
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_q <= 16'h0000;
    end else if (ce) begin
      div_cnt_q <= (!en || baud_tick) ? 16'h0000 : div_cnt_q + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Transmit FIFO and shifter
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_rp_q <= 2'b00;
      tx_cnt_q <= 3'd0;
      tx_state_q <= ufcs_pkg::TX_IDLE;
      tx_os_q <= 5'd0;
      tx_idx_q <= 4'h0;
      tx_sh_q <= 9'h000;
      tx_brk_run_q <= 1'b0;
    end else if (ce) begin
      if (tx_flush) begin
        tx_rp_q <= 2'b00;
        tx_cnt_q <= 3'd0;
        tx_state_q <= ufcs_pkg::TX_IDLE;
        tx_os_q <= 5'd0;
        tx_idx_q <= 4'h0;
      end else begin
        if (tx_push) begin
          tx_mem_q[fifo_wp(tx_rp_q, tx_cnt_q)] <= pwdata[8:0];
        end
        tx_rp_q <= tx_rp_q + {1'b0, tx_load};
        tx_cnt_q <= tx_cnt_q + {2'b00, tx_push} - {2'b00, tx_load};
        if (tx_start) begin
          tx_state_q <= ufcs_pkg::TX_START;
          tx_os_q <= 5'd0;
          tx_idx_q <= 4'h0;
          tx_brk_run_q <= brk_q;
          if (tx_load) begin
            tx_sh_q <= nine ? tx_mem_q[tx_rp_q] : {par_bit(tx_mem_q[tx_rp_q][7:0], par_odd),
              tx_mem_q[tx_rp_q][7:0]};
          end
        end else if (tx_state_q != ufcs_pkg::TX_IDLE && baud_tick) begin
          tx_os_q <= tx_bit_end ? 5'd0 : tx_os_q + 5'd1;
          if (tx_bit_end) begin
            tx_state_q <= tx_nstate;
            tx_idx_q <= tx_nidx;
            if (tx_state_q == ufcs_pkg::TX_DATA && !nine) begin
              tx_sh_q <= {tx_sh_q[8], tx_sh_q[8], tx_sh_q[7:1]};
            end else if (tx_state_q == ufcs_pkg::TX_DATA) begin
              tx_sh_q <= {1'b0, tx_sh_q[8:1]};
            end
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Receive sampler and FIFO
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_rp_q <= 2'b00;
      rx_cnt_q <= 3'd0;
      rx_state_q <= ufcs_pkg::RX_IDLE;
      rx_os_q <= 5'd0;
      rx_idx_q <= 4'h0;
      rx_sh_q <= 9'h000;
      rx_parity_error_q <= 1'b0;
    end else if (ce) begin
      rx_s1_q <= serial_receive_line;
      rx_s2_q <= rx_s1_q;
      if (rx_flush) begin
        rx_rp_q <= 2'b00;
        rx_cnt_q <= 3'd0;
        rx_state_q <= ufcs_pkg::RX_IDLE;
        rx_os_q <= 5'd0;
      end else begin
        if (rx_push) begin
          rx_mem_q[fifo_wp(rx_rp_q, rx_cnt_q)] <= {rx_parity_error_q, ~rx_level, rx_sh_q};
        end
        rx_rp_q <= rx_rp_q + {1'b0, rx_pop};
        rx_cnt_q <= rx_cnt_q + {2'b00, rx_push} - {2'b00, rx_pop};
        if (rx_state_q == ufcs_pkg::RX_IDLE) begin
          rx_os_q <= 5'd0;
          if (!rx_level) begin
            rx_state_q <= ufcs_pkg::RX_START;
          end
        end else if (rx_state_q == ufcs_pkg::RX_START) begin
          if (baud_tick && rx_os_q == osr_half) begin
            rx_os_q <= 5'd0;
            rx_idx_q <= 4'h0;
            rx_sh_q <= 9'h000;
            rx_parity_error_q <= 1'b0;
            rx_state_q <= rx_level ? ufcs_pkg::RX_IDLE : ufcs_pkg::RX_DATA;
          end else if (baud_tick) begin
            rx_os_q <= rx_os_q + 5'd1;
          end
        end else if (baud_tick) begin
          rx_os_q <= rx_sample ? 5'd0 : rx_os_q + 5'd1;
          if (rx_sample) begin
            unique case (rx_state_q)
              ufcs_pkg::RX_DATA: begin
                rx_sh_q[rx_idx_q] <= rx_level;
                rx_idx_q <= rx_idx_q + 4'h1;
                if (rx_idx_q == data_last) begin
                  rx_state_q <= par_on ? ufcs_pkg::RX_PAR : ufcs_pkg::RX_STOP;
                end
              end
              ufcs_pkg::RX_PAR: begin
                rx_parity_error_q <= rx_level != par_bit(rx_sh_q[7:0], par_odd);
                rx_state_q <= ufcs_pkg::RX_STOP;
              end
              default: begin
                rx_state_q <= ufcs_pkg::RX_IDLE;
              end
            endcase
          end
        end
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign serial_transmit_line = tx_line_q;
  assign serial_transmit_oe = tx_oe_q;
  assign tx_irq = tx_irq_q;
  assign rx_irq = rx_irq_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_break_zeros: assert property (tx_state_q == ufcs_pkg::TX_BRK |-> !tx_level)
    else $error("break bit not low");
  a_tx_disable_flush: assert property (ce && !txen |=> tx_cnt_q == 3'd0 && tx_state_q == ufcs_pkg::TX_IDLE && !tx_oe_q)
    else $error("transmit disable did not flush");
  a_txbf_flag: assert property (ce && tx_full && !tx_flush && !tx_start |=> stat_word[`UFCS_S_TXBF])
    else $error("buffer full flag wrong");
  a_transmitter_empty_busy: assert property (ce && tx_push |=> !stat_word[`UFCS_S_TRANSMITTER_EMPTY])
    else $error("empty flag set while busy");
  a_overrun_set: assert property (ce && rx_end && rx_keep && rx_full |=> overrun_error_q)
    else $error("overrun not flagged");
  a_avail_flag: assert property (ce && rx_push |=> stat_word[`UFCS_S_AVAIL])
    else $error("data available flag wrong");
  a_fifo_bound: assert property (tx_cnt_q <= `UFCS_DEPTH && rx_cnt_q <= `UFCS_DEPTH)
    else $error("fifo count overflow");
  a_stop_level: assert property (tx_state_q == ufcs_pkg::TX_STOP |-> tx_level)
    else $error("stop bit not at idle level");
  a_addr_filter: assert property (ce && rx_end && address_detect_enable && nine && !rx_sh_q[8] |=> $stable(rx_cnt_q) || rx_cnt_q < $past(rx_cnt_q))
    else $error("address filter let data through");
  a_receiver_idle_flag: assert property (ce && rx_state_q == ufcs_pkg::RX_IDLE && !rx_level && !rx_flush |=> !stat_word[`UFCS_S_RECEIVER_IDLE])
    else $error("receiver idle flag stuck");

endmodule

// file: ufcs_cfg.svh
// Constants of the serial transceiver: register offsets, bit positions,
// reset values, frame and oversampling figures.
// Assumes inclusion by bare name from the design and from the bench.
`ifndef UFCS_CFG_SVH
`define UFCS_CFG_SVH

// ---------------------------------------------------------------
// Register byte offsets on APB
// ---------------------------------------------------------------
`define UFCS_OFF_MODE 12'h000
`define UFCS_OFF_STAT 12'h004
`define UFCS_OFF_TXD 12'h008
`define UFCS_OFF_RXD 12'h00c
`define UFCS_OFF_DIV 12'h010

// ---------------------------------------------------------------
// Mode register fields
// ---------------------------------------------------------------
`define UFCS_M_EN 15
`define UFCS_M_INFRARED_CODEC_ENABLE 12
`define UFCS_M_RXINV 4
`define UFCS_M_HIGH_SPEED_BAUD_SELECT 3
`define UFCS_M_PDS_HI 2
`define UFCS_M_PDS_LO 1
`define UFCS_M_STOP_BITS_SELECT 0
`define UFCS_MODE_WMASK 16'h901f
`define UFCS_MODE_RST 16'h0000

// ---------------------------------------------------------------
// Status and control register fields
// ---------------------------------------------------------------
`define UFCS_S_TXI1 15
`define UFCS_S_TXINV 14
`define UFCS_S_TXI0 13
`define UFCS_S_BRK 11
`define UFCS_S_TXEN 10
`define UFCS_S_TXBF 9
`define UFCS_S_TRANSMITTER_EMPTY 8
`define UFCS_S_RXI_HI 7
`define UFCS_S_RXI_LO 6
`define UFCS_S_ADDRESS_DETECT_ENABLE 5
`define UFCS_S_RECEIVER_IDLE 4
`define UFCS_S_PARITY_ERROR 3
`define UFCS_S_FRAMING_ERROR 2
`define UFCS_S_OVERRUN_ERROR 1
`define UFCS_S_AVAIL 0
`define UFCS_STAT_WMASK 16'he4e0
`define UFCS_CTL_RST 16'h0000
`define UFCS_DIV_RST 16'h0000

// ---------------------------------------------------------------
// Codes and frame figures
// ---------------------------------------------------------------
`define UFCS_PDS_9N 2'b11
`define UFCS_PDS_8O 2'b10
`define UFCS_PDS_8E 2'b01
`define UFCS_TXI_EACH 2'b00
`define UFCS_TXI_EMPTY 2'b10
`define UFCS_TXI_DONE 2'b01
`define UFCS_RXI_FULL 2'b11
`define UFCS_RXI_3Q 2'b10
`define UFCS_OSR_HI 5'd4
`define UFCS_OSR_STD 5'd16
`define UFCS_IR_PULSE 5'd3
`define UFCS_BRK_LAST 4'd11
`define UFCS_LAST9 4'd8
`define UFCS_LAST8 4'd7
`define UFCS_DEPTH 3'd4
`define UFCS_LVL_3Q 3'd2
`define UFCS_LVL_FULL 3'd3

`endif

// file: ufcs_pkg.sv
// Types of the serial transceiver: transmit and receive state codes.
// Assumes nothing of its surroundings.
package ufcs_pkg;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b010,
    TX_PAR = 3'b011,
    TX_BRK = 3'b100,
    TX_STOP = 3'b101
  } ufcs_tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_PAR = 3'b011,
    RX_STOP = 3'b100
  } ufcs_rx_state_t;

endpackage

// file: ufcs_node.sv
// Remote serial node: sends frames to the receive line, decodes the transmit line.
// Assumes one bit lasts a whole number of clk cycles, given by the caller.
`timescale 1ns/1ps

module ufcs_node (
  // Clock
  input wire logic clk,
  // Serial lines seen from the far side
  input wire logic tx_line,
  output logic rx_line
);
  // Pull-up keeps the line high when idle
  initial rx_line = 1'b1;

  // ---------------------------------------------------------------
  // Frame sender; a low stop is cut short so no false start follows
  // ---------------------------------------------------------------
  task automatic send(input logic [8:0] d, input int nb, input int np, input logic pv, input logic sb,
                      input int bp);
    int i;
    @(posedge clk);
    rx_line <= 1'b0;
    repeat (bp) @(posedge clk);
    for (i = 0; i < nb; i++) begin
      rx_line <= d[i];
      repeat (bp) @(posedge clk);
    end
    if (np != 0) begin
      rx_line <= pv;
      repeat (bp) @(posedge clk);
    end
    rx_line <= sb;
    repeat (sb ? bp : bp / 2 + 4) @(posedge clk);
    rx_line <= 1'b1;
    repeat (2 * bp) @(posedge clk);
  endtask

  // ---------------------------------------------------------------
  // Frame decoder, sampling at mid-bit
  // ---------------------------------------------------------------
  task automatic capture(output logic [8:0] d, output logic stop_ok, input int nb, input int bp);
    int i;
    d = 9'h000;
    while (tx_line !== 1'b0) @(posedge clk);
    repeat (bp / 2) @(posedge clk);
    for (i = 0; i < nb; i++) begin
      repeat (bp) @(posedge clk);
      d[i] = tx_line;
    end
    repeat (bp) @(posedge clk);
    stop_ok = tx_line;
  endtask
endmodule

// file: ufcs_uart_tb_top.sv
// Self-checking bench of the serial transceiver over APB and its serial lines.
// Assumes the remote node model and the shared constants header.
`timescale 1ns/1ps
`include "ufcs_cfg.svh"

module ufcs_uart_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic serial_receive_line;
  logic serial_transmit_line;
  logic serial_transmit_oe;
  logic tx_irq;
  logic rx_irq;
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  int rx_events = 0;
  int tx_events = 0;
  logic [31:0] rd;
  logic err;
  logic [8:0] got;
  logic stop_ok;
  int i;

  always #4 pclk = ~pclk;

  ufcs_uart ufcs_uart_inst (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_receive_line(serial_receive_line), .serial_transmit_line(serial_transmit_line),
    .serial_transmit_oe(serial_transmit_oe), .tx_irq(tx_irq), .rx_irq(rx_irq));

  ufcs_node ufcs_node_inst (.clk(pclk), .tx_line(serial_transmit_line), .rx_line(serial_receive_line));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic complete_run();
    if (errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (rx_irq === 1'b1) rx_events++;
    if (tx_irq === 1'b1) tx_events++;
    if (cycles == 60000) begin
      errors++;
      complete_run();
    end
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    apb(1'b0, `UFCS_OFF_STAT, 32'h0);
    chk(rd, 32'h00000110);
    apb(1'b0, `UFCS_OFF_MODE, 32'h0);
    chk(rd, 32'h00000000);
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, err}, 32'h1);
  endtask

  task automatic t_tx();
    apb(1'b1, `UFCS_OFF_MODE, 32'h8008);
    apb(1'b1, `UFCS_OFF_STAT, 32'h0400);
    apb(1'b1, `UFCS_OFF_TXD, 32'h0a5);
    chk({31'h0, serial_transmit_oe}, 32'h1);
    ufcs_node_inst.capture(got, stop_ok, 8, 4);
    chk({23'h0, got}, 32'h0a5);
    chk({31'h0, stop_ok}, 32'h1);
    repeat (20) @(posedge pclk);
    apb(1'b0, `UFCS_OFF_STAT, 32'h0);
    chk(rd & 32'h300, 32'h100);
  endtask

  task automatic t_fill();
    for (i = 0; i < 5; i++) apb(1'b1, `UFCS_OFF_TXD, 32'h10 + i);
    apb(1'b0, `UFCS_OFF_STAT, 32'h0);
    chk(rd & 32'h300, 32'h200);
    apb(1'b1, `UFCS_OFF_STAT, 32'h0);
    apb(1'b0, `UFCS_OFF_STAT, 32'h0);
    chk(rd & 32'h300, 32'h100);
    chk({31'h0, serial_transmit_oe}, 32'h0);
  endtask

  task automatic t_rx_err();
    apb(1'b1, `UFCS_OFF_MODE, 32'h8002);
    ufcs_node_inst.send(9'h03c, 8, 1, 1'b1, 1'b1, 16);
    ufcs_node_inst.send(9'h03c, 8, 1, 1'b0, 1'b0, 16);
    apb(1'b0, `UFCS_OFF_STAT, 32'h0);
    chk(rd & 32'h1d, 32'h19);
    apb(1'b0, `UFCS_OFF_RXD, 32'h0);
    chk(rd, 32'h03c);
    apb(1'b0, `UFCS_OFF_STAT, 32'h0);
    chk(rd & 32'h0d, 32'h05);
    apb(1'b0, `UFCS_OFF_RXD, 32'h0);
    apb(1'b0, `UFCS_OFF_STAT, 32'h0);
    chk(rd & 32'h01, 32'h0);
  endtask

  task automatic t_ovr();
    apb(1'b1, `UFCS_OFF_MODE, 32'h8000);
    rx_events = 0;
    for (i = 0; i < 5; i++) ufcs_node_inst.send(9'h10 + i, 8, 0, 1'b0, 1'b1, 16);
    chk(rx_events, 4);
    apb(1'b0, `UFCS_OFF_STAT, 32'h0);
    chk(rd & 32'h03, 32'h03);
    apb(1'b0, `UFCS_OFF_RXD, 32'h0);
    chk(rd, 32'h010);
    apb(1'b1, `UFCS_OFF_STAT, 32'h0);
    apb(1'b0, `UFCS_OFF_STAT, 32'h0);
    chk(rd, 32'h110);
  endtask

  task automatic t_addr();
    apb(1'b1, `UFCS_OFF_MODE, 32'h8006);
    apb(1'b1, `UFCS_OFF_STAT, 32'h0020);
    ufcs_node_inst.send(9'h055, 9, 0, 1'b0, 1'b1, 16);
    ufcs_node_inst.send(9'h1aa, 9, 0, 1'b0, 1'b1, 16);
    apb(1'b0, `UFCS_OFF_RXD, 32'h0);
    chk(rd, 32'h1aa);
    apb(1'b0, `UFCS_OFF_STAT, 32'h0);
    chk(rd & 32'h01, 32'h0);
  endtask

  task automatic t_brk();
    apb(1'b1, `UFCS_OFF_MODE, 32'h8009);
    tx_events = 0;
    apb(1'b1, `UFCS_OFF_STAT, 32'h2c00);
    ufcs_node_inst.capture(got, stop_ok, 8, 4);
    chk({22'h0, got, stop_ok}, 32'h0);
    repeat (30) @(posedge pclk);
    apb(1'b0, `UFCS_OFF_STAT, 32'h0);
    chk(rd & 32'h0900, 32'h0100);
    chk(tx_events, 1);
    apb(1'b1, `UFCS_OFF_TXD, 32'h0c3);
    apb(1'b1, `UFCS_OFF_TXD, 32'h05a);
    ufcs_node_inst.capture(got, stop_ok, 8, 4);
    chk({22'h0, got, stop_ok}, 32'h187);
    repeat (4) @(posedge pclk);
    chk({31'h0, serial_transmit_line}, 32'h1);
    ufcs_node_inst.capture(got, stop_ok, 8, 4);
    chk({22'h0, got, stop_ok}, 32'h0b5);
    repeat (20) @(posedge pclk);
    chk(tx_events, 2);
  endtask

  task automatic t_inv();
    apb(1'b1, `UFCS_OFF_STAT, 32'h4400);
    repeat (3) @(posedge pclk);
    chk({31'h0, serial_transmit_line}, 32'h0);
    apb(1'b1, `UFCS_OFF_MODE, 32'h9000);
    repeat (3) @(posedge pclk);
    chk({31'h0, serial_transmit_line}, 32'h1);
    apb(1'b1, `UFCS_OFF_MODE, 32'h9008);
    repeat (3) @(posedge pclk);
    chk({31'h0, serial_transmit_line}, 32'h0);
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_tx();
    t_fill();
    t_rx_err();
    t_ovr();
    t_addr();
    t_brk();
    t_inv();
    complete_run();
  end
endmodule
